// File: hw/intp_map.svh
// Constants, offsets, field positions and reset values of the two-axis interpolator.
`ifndef INTP_MAP_SVH
`define INTP_MAP_SVH
// Contract
// - Linear move drives both axes along line
// - Linear displacement stays within 134217728 pulses
// - Linear move releases sequencer at once
// - Single linear move may use trapezoid
// - No smooth profiles for linear moves
// - Chained linear moves use constant speed
// - Speed comes from X preset only
// - Centre command stores offset, releases at once
// - Clockwise arc around stored centre
// - Anticlockwise arc around stored centre
// - Zero end point traces full circle
// - Arc moves use constant speed only
// - Arc end exact when points on axes
// - Positive value moves plus direction
// - Both axes receive command together
// - Operands scaled by numerator over denominator
// - Chained segments last three milliseconds minimum (not enforced: the device ignores cmd_chain)
// - Other commands break chained continuity
`define OP_W       32
`define PER_W      16
`define SCL_W      16
`define PROD_W     48
`define LIN_MAX    32'sh08000000
`define ARC_MAX    32'sh0FFFFFFF
`define RAMP_SPAN  16'h0040
`define PER_RST    16'h03E8
`define SCL_RST    16'h0001
`define A_CMD      8'h00
`define A_DX       8'h04
`define A_DY       8'h08
`define A_SCALE    8'h0C
`define A_PER      4'h1
`define A_STATUS   8'h20
`define A_POSX     8'h24
`define A_POSY     8'h28
`define F_CODE     1:0
`define F_SPD      3:2
`define F_PROF     5:4
`define F_CHAIN    6
`define F_NUM      15:0
`define F_DEN      31:16
`endif

// File: hw/intp_pkg.sv
// Command and profile types shared by both ends of the interpolator link, and the device's own state type.
package intp_pkg;
	typedef enum logic [1:0] {
		linear_move_cmd, arc_centre_cmd, clockwise_arc_cmd, anticlockwise_arc_cmd
	} cmd_t;
	typedef enum logic [1:0] {
		constant_speed, trapezoid, smooth_profile_one, smooth_profile_two
	} prof_t;
	typedef enum logic [1:0] {st_idle, st_scale, st_prep, st_run} dev_state_t;
endpackage

// File: hw/intp_if.sv
// Link between the command sequencer and the interpolator.
`timescale 1ns/1ps
`include "intp_map.svh"
interface intp_if;
	logic                           cmd_valid;
	logic                           cmd_ready;
	logic                           cmd_chain;
	intp_pkg::cmd_t                 cmd_code;
	intp_pkg::prof_t                cmd_profile;
	logic [1:0]                     speed_preset_select_x;
	logic [1:0]                     speed_preset_select_y;
	logic signed [`OP_W-1:0]        cmd_dx;
	logic signed [`OP_W-1:0]        cmd_dy;
	logic [`SCL_W-1:0]              scale_num;
	logic [`SCL_W-1:0]              scale_den;
	logic [3:0][`PER_W-1:0]         preset_period;
	logic                           busy;
	logic signed [`OP_W-1:0]        pos_x;
	logic signed [`OP_W-1:0]        pos_y;
	logic                           step_x;
	logic                           dir_x;
	logic                           step_y;
	logic                           dir_y;
	modport device (input cmd_valid, cmd_chain, cmd_code, cmd_profile, speed_preset_select_x,
		speed_preset_select_y, cmd_dx, cmd_dy, scale_num, scale_den, preset_period,
		output cmd_ready, busy, pos_x, pos_y, step_x, dir_x, step_y, dir_y);
	modport sequencer (output cmd_valid, cmd_chain, cmd_code, cmd_profile, speed_preset_select_x,
		speed_preset_select_y, cmd_dx, cmd_dy, scale_num, scale_den, preset_period,
		input cmd_ready, busy, pos_x, pos_y, step_x, dir_x, step_y, dir_y);
endinterface

// File: hw/intp_step_timer.sv
// Step rate generator with optional trapezoid ramp.
`timescale 1ns/1ps
`include "intp_map.svh"
module intp_step_timer #(
	parameter int PER_W = `PER_W
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              start,
	input  wire logic              run,
	input  wire logic              trap,
	input  wire logic [PER_W-1:0]  period,
	input  wire logic [31:0]       left,
	output logic                   tick
);
	if (PER_W < 8 || PER_W > 31) begin : bad_width
		$error("Period width out of range.");
	end

	typedef struct packed {
		logic [PER_W-1:0] cur;
		logic [PER_W-1:0] ramp;
		logic [PER_W-1:0] cnt;
		logic             tick;
	} tim_t;

	tim_t s;
	tim_t next_s;
	logic [PER_W-1:0] top;

	// ----------------------------------------------------------------
	// Rate and ramp.
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		top = period + PER_W'(`RAMP_SPAN);
		if (start) begin
			next_s.cur = trap ? top : period;
			next_s.ramp = '0;
			next_s.cnt = '0;
		end else if (run) begin
			if (PER_W'(s.cnt + 1'b1) >= s.cur) begin
				next_s.cnt = '0;
				next_s.tick = 1'b1;
				if (trap) begin
					if (left <= 32'(s.ramp) && s.cur < top) begin
						next_s.cur = s.cur + 1'b1;
						next_s.ramp = s.ramp - 1'b1;
					end else if (s.cur > period) begin
						next_s.cur = s.cur - 1'b1;
						next_s.ramp = s.ramp + 1'b1;
					end
				end
			end else begin
				next_s.cnt = s.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign tick = s.tick;
endmodule

// File: hw/intp_device.sv
// Two-axis interpolator: linear and circular moves producing step pulses.
`timescale 1ns/1ps
`include "intp_map.svh"
module intp_device (
	input  wire logic     pclk,
	input  wire logic     presetn,
	input  wire logic     ce,
	intp_if.device        lnk
);
	import intp_pkg::*;

	typedef struct packed {
		dev_state_t               st;
		logic                     rdy;
		logic                     nv;
		cmd_t                     ncode;
		logic                     ntrap;
		logic [`PER_W-1:0]        nper;
		logic signed [`OP_W-1:0]  ndx;
		logic signed [`OP_W-1:0]  ndy;
		cmd_t                     code;
		logic                     trap;
		logic [`PER_W-1:0]        per;
		logic [`PROD_W-1:0]       qx;
		logic [`PROD_W-1:0]       qy;
		logic [`SCL_W-1:0]        remx;
		logic [`SCL_W-1:0]        remy;
		logic                     sgx;
		logic                     sgy;
		logic [5:0]               bits;
		logic signed [`OP_W-1:0]  pos_x;
		logic signed [`OP_W-1:0]  pos_y;
		logic signed [`OP_W-1:0]  cen_x;
		logic signed [`OP_W-1:0]  cen_y;
		logic signed [`OP_W-1:0]  tgt_x;
		logic signed [`OP_W-1:0]  tgt_y;
		logic [31:0]              adx;
		logic [31:0]              ady;
		logic [31:0]              nmaj;
		logic [31:0]              cnt;
		logic [31:0]              acc;
		logic                     xmaj;
		logic                     sdx;
		logic                     sdy;
		logic signed [63:0]       err;
		logic                     fin_axis;
		logic                     start;
		logic                     busy;
		logic                     step_x;
		logic                     dir_x;
		logic                     step_y;
		logic                     dir_y;
	} dev_t;

	dev_t s;
	dev_t next_s;
	logic tick;

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	function automatic logic [`PROD_W-1:0] scale_mag(input logic signed [`OP_W-1:0] v,
		input logic [`SCL_W-1:0] m);
		logic [`OP_W-1:0] mag;
		mag = v[`OP_W-1] ? `OP_W'(-v) : `OP_W'(v);
		return `PROD_W'(mag) * `PROD_W'(m);
	endfunction

	function automatic logic [`SCL_W+`PROD_W-1:0] div_step(input logic [`SCL_W-1:0] r,
		input logic [`PROD_W-1:0] q, input logic [`SCL_W-1:0] d);
		logic [`SCL_W:0] t;
		t = {r, q[`PROD_W-1]};
		if (t >= {1'b0, d}) begin
			return {`SCL_W'(t - {1'b0, d}), q[`PROD_W-2:0], 1'b1};
		end
		return {t[`SCL_W-1:0], q[`PROD_W-2:0], 1'b0};
	endfunction

	function automatic logic signed [`OP_W-1:0] signed_q(input logic [`PROD_W-1:0] q,
		input logic neg);
		return neg ? `OP_W'(-$signed(q[`OP_W-1:0])) : $signed(q[`OP_W-1:0]);
	endfunction

	function automatic logic [31:0] mag32(input logic signed [`OP_W-1:0] v);
		return v[`OP_W-1] ? 32'(-v) : 32'(v);
	endfunction

	function automatic logic [63:0] abs64(input logic signed [63:0] v);
		return v[63] ? 64'(-v) : 64'(v);
	endfunction

	function automatic logic near1(input logic signed [`OP_W-1:0] v);
		return unsigned'(`OP_W'(v + 32'sh1)) <= 32'h2;
	endfunction

	// ----------------------------------------------------------------
	// Step rate.
	// ----------------------------------------------------------------
	intp_step_timer #(.PER_W(`PER_W)) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.start   (s.start),
		.run     (s.st == st_run),
		.trap    (s.trap),
		.period  (s.per),
		.left    (32'(s.nmaj - s.cnt)),
		.tick    (tick)
	);

	// ----------------------------------------------------------------
	// Command intake, scaling and interpolation.
	// ----------------------------------------------------------------
	logic [`SCL_W-1:0]       den;
	logic signed [`OP_W-1:0] vx;
	logic signed [`OP_W-1:0] vy;
	logic signed [`OP_W-1:0] rxv;
	logic signed [`OP_W-1:0] ryv;
	logic signed [63:0]      dxs;
	logic signed [63:0]      dys;
	logic signed [63:0]      ex;
	logic signed [63:0]      ey;
	logic signed [63:0]      exy;
	logic [31:0]             minor;
	logic [31:0]             acc2;
	logic                    cw;
	logic                    sx;
	logic                    sy;
	logic                    mx;
	logic                    my;

	always_comb begin
		next_s = s;
		next_s.step_x = 1'b0;
		next_s.step_y = 1'b0;
		next_s.start = 1'b0;
		den = (lnk.scale_den == '0) ? `SCL_W'(1) : lnk.scale_den;
		vx = signed_q(s.qx, s.sgx);
		vy = signed_q(s.qy, s.sgy);
		rxv = s.pos_x - s.cen_x;
		ryv = s.pos_y - s.cen_y;
		cw = (s.code == clockwise_arc_cmd);
		sx = cw ? ~ryv[`OP_W-1] : ryv[`OP_W-1];
		sy = cw ? rxv[`OP_W-1] : ~rxv[`OP_W-1];
		dxs = sx ? 64'(rxv) : 64'(-rxv);
		dys = sy ? 64'(ryv) : 64'(-ryv);
		ex = s.err + 2 * dxs + 64'sh1;
		ey = s.err + 2 * dys + 64'sh1;
		exy = ex + 2 * dys + 64'sh1;
		minor = s.xmaj ? s.ady : s.adx;
		acc2 = s.acc + minor;
		mx = 1'b0;
		my = 1'b0;
		if (lnk.cmd_valid && s.rdy) begin
			next_s.nv = 1'b1;
			next_s.ncode = lnk.cmd_code;
			next_s.ndx = lnk.cmd_dx;
			next_s.ndy = lnk.cmd_dy;
			next_s.ntrap = (lnk.cmd_profile == trapezoid) && (lnk.cmd_code == linear_move_cmd);
			next_s.nper = lnk.preset_period[lnk.speed_preset_select_x];
		end
		unique case (s.st)
			st_idle: begin
				if (s.nv) begin
					next_s.nv = 1'b0;
					next_s.code = s.ncode;
					next_s.trap = s.ntrap;
					next_s.per = s.nper;
					next_s.qx = scale_mag(s.ndx, lnk.scale_num);
					next_s.qy = scale_mag(s.ndy, lnk.scale_num);
					next_s.sgx = s.ndx[`OP_W-1];
					next_s.sgy = s.ndy[`OP_W-1];
					next_s.remx = '0;
					next_s.remy = '0;
					next_s.bits = '0;
					next_s.busy = 1'b1;
					next_s.st = st_scale;
				end
			end
			st_scale: begin
				{next_s.remx, next_s.qx} = div_step(s.remx, s.qx, den);
				{next_s.remy, next_s.qy} = div_step(s.remy, s.qy, den);
				next_s.bits = s.bits + 1'b1;
				if (s.bits == 6'(`PROD_W - 1)) begin
					next_s.st = st_prep;
				end
			end
			st_prep: begin
				next_s.tgt_x = s.pos_x + vx;
				next_s.tgt_y = s.pos_y + vy;
				next_s.cnt = '0;
				next_s.err = '0;
				next_s.start = 1'b1;
				next_s.st = st_run;
				if (s.code == arc_centre_cmd) begin
					next_s.cen_x = s.pos_x + vx;
					next_s.cen_y = s.pos_y + vy;
					next_s.start = 1'b0;
					next_s.busy = next_s.nv;
					next_s.st = st_idle;
				end else if (s.code == linear_move_cmd) begin
					next_s.adx = mag32(vx);
					next_s.ady = mag32(vy);
					next_s.xmaj = mag32(vx) >= mag32(vy);
					next_s.nmaj = (mag32(vx) >= mag32(vy)) ? mag32(vx) : mag32(vy);
					next_s.acc = ((mag32(vx) >= mag32(vy)) ? mag32(vx) : mag32(vy)) >> 1;
					next_s.sdx = ~vx[`OP_W-1];
					next_s.sdy = ~vy[`OP_W-1];
				end else begin
					next_s.nmaj = '1;
					next_s.fin_axis = (s.pos_x + vx == s.cen_x) || (s.pos_y + vy == s.cen_y);
				end
			end
			st_run: begin
				if (s.code == linear_move_cmd) begin
					if (s.cnt == s.nmaj) begin
						next_s.busy = next_s.nv;
						next_s.st = st_idle;
					end else if (tick) begin
						next_s.cnt = s.cnt + 32'h1;
						next_s.acc = (acc2 >= s.nmaj) ? acc2 - s.nmaj : acc2;
						mx = s.xmaj || acc2 >= s.nmaj;
						my = !s.xmaj || acc2 >= s.nmaj;
						sx = s.sdx;
						sy = s.sdy;
					end
				end else if (s.cnt >= 32'h2 && (s.fin_axis ? (s.tgt_x == s.pos_x &&
					s.tgt_y == s.pos_y) : (near1(s.tgt_x - s.pos_x) &&
					near1(s.tgt_y - s.pos_y)))) begin
					next_s.busy = next_s.nv;
					next_s.st = st_idle;
				end else if (tick) begin
					next_s.cnt = s.cnt + 32'h1;
					if (abs64(exy) <= abs64(ex) && abs64(exy) <= abs64(ey)) begin
						mx = 1'b1;
						my = 1'b1;
						next_s.err = exy;
					end else if (abs64(ex) <= abs64(ey)) begin
						mx = 1'b1;
						next_s.err = ex;
					end else begin
						my = 1'b1;
						next_s.err = ey;
					end
				end
			end
		endcase
		if (mx) begin
			next_s.step_x = 1'b1;
			next_s.dir_x = sx;
			next_s.pos_x = sx ? s.pos_x + 32'sh1 : s.pos_x - 32'sh1;
		end
		if (my) begin
			next_s.step_y = 1'b1;
			next_s.dir_y = sy;
			next_s.pos_y = sy ? s.pos_y + 32'sh1 : s.pos_y - 32'sh1;
		end
		next_s.rdy = !next_s.nv;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign lnk.cmd_ready = s.rdy;
	assign lnk.busy = s.busy;
	assign lnk.pos_x = s.pos_x;
	assign lnk.pos_y = s.pos_y;
	assign lnk.step_x = s.step_x;
	assign lnk.dir_x = s.dir_x;
	assign lnk.step_y = s.step_y;
	assign lnk.dir_y = s.dir_y;
endmodule

// File: hw/intp_sequencer.sv
// Command sequencer end: APB registers that issue interpolation commands.
`timescale 1ns/1ps
`include "intp_map.svh"
module intp_sequencer (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	intp_if.sequencer         lnk
);
	import intp_pkg::*;

	typedef struct packed {
		logic [31:0]              dx;
		logic [31:0]              dy;
		logic [`SCL_W-1:0]        num;
		logic [`SCL_W-1:0]        den;
		logic [3:0][`PER_W-1:0]   per;
		logic                     pend;
		cmd_t                     code;
		logic [1:0]               spd;
		prof_t                    prof;
		logic                     chain;
		logic                     refused;
		logic                     pready;
		logic                     pslverr;
		logic [31:0]              prdata;
	} seq_t;

	seq_t s;
	seq_t next_s;

	function automatic logic in_range(input logic signed [31:0] v, input logic signed [31:0] m);
		return v <= m && v >= -m;
	endfunction

	// ----------------------------------------------------------------
	// Register access and command issue.
	// ----------------------------------------------------------------
	cmd_t                code;
	prof_t               prof;
	logic signed [31:0]  lim;
	logic                ok;

	always_comb begin
		next_s = s;
		code = cmd_t'(pwdata[`F_CODE]);
		prof = prof_t'(pwdata[`F_PROF]);
		lim = (code == linear_move_cmd) ? `LIN_MAX : `ARC_MAX;
		ok = !s.pend && in_range(s.dx, lim) && in_range(s.dy, lim);
		if (code == linear_move_cmd) begin
			ok = ok && prof != smooth_profile_one && prof != smooth_profile_two;
			ok = ok && (!pwdata[`F_CHAIN] || prof == constant_speed);
		end else if (code != arc_centre_cmd) begin
			ok = ok && prof == constant_speed;
		end
		if (s.pend && lnk.cmd_ready) begin
			next_s.pend = 1'b0;
		end
		if (psel && !penable) begin
			next_s.pready = 1'b1;
			next_s.pslverr = 1'b0;
			next_s.prdata = '0;
			if (paddr[7:4] == `A_PER && paddr[1:0] == 2'h0) begin
				next_s.prdata = 32'(s.per[paddr[3:2]]);
			end else begin
				unique case (paddr)
					`A_CMD:    next_s.prdata = {25'h0, s.chain, s.prof, s.spd, s.code};
					`A_DX:     next_s.prdata = s.dx;
					`A_DY:     next_s.prdata = s.dy;
					`A_SCALE:  next_s.prdata = {s.den, s.num};
					`A_STATUS: next_s.prdata = {29'h0, s.refused, lnk.busy, s.pend};
					`A_POSX:   next_s.prdata = lnk.pos_x;
					`A_POSY:   next_s.prdata = lnk.pos_y;
					default:   next_s.pslverr = 1'b1;
				endcase
			end
		end else if (s.pready && psel && penable) begin
			next_s.pready = 1'b0;
			next_s.pslverr = 1'b0;
			if (pwrite && !s.pslverr) begin
				if (paddr[7:4] == `A_PER) begin
					next_s.per[paddr[3:2]] = pwdata[`PER_W-1:0];
				end else if (paddr == `A_DX) begin
					next_s.dx = pwdata;
				end else if (paddr == `A_DY) begin
					next_s.dy = pwdata;
				end else if (paddr == `A_SCALE) begin
					next_s.num = pwdata[`F_NUM];
					next_s.den = pwdata[`F_DEN];
				end else if (paddr == `A_CMD) begin
					next_s.refused = !ok;
					if (ok) begin
						next_s.pend = 1'b1;
						next_s.code = code;
						next_s.prof = prof;
						next_s.spd = pwdata[`F_SPD];
						next_s.chain = pwdata[`F_CHAIN];
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.num <= `SCL_RST;
			s.den <= `SCL_RST;
			s.per <= {4{`PER_RST}};
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign lnk.cmd_valid = s.pend;
	assign lnk.cmd_chain = s.chain;
	assign lnk.cmd_code = s.code;
	assign lnk.cmd_profile = s.prof;
	assign lnk.speed_preset_select_x = s.spd;
	assign lnk.speed_preset_select_y = s.spd;
	assign lnk.cmd_dx = s.dx;
	assign lnk.cmd_dy = s.dy;
	assign lnk.scale_num = s.num;
	assign lnk.scale_den = s.den;
	assign lnk.preset_period = s.per;
endmodule

// File: sim/intp_monitor.sv
// Concurrent checks on the link between sequencer and interpolator.
`timescale 1ns/1ps
`include "intp_map.svh"
module intp_monitor (
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic                    cmd_valid,
	input wire logic                    cmd_ready,
	input wire logic                    cmd_chain,
	input wire intp_pkg::cmd_t          cmd_code,
	input wire intp_pkg::prof_t         cmd_profile,
	input wire logic signed [`OP_W-1:0] cmd_dx,
	input wire logic                    busy,
	input wire logic                    step_x,
	input wire logic                    step_y
);
	import intp_pkg::*;
	// ----------------------------------------
	// Handshake and motion checks.
	// ----------------------------------------
	default clocking mon_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire take = cmd_valid && cmd_ready;
	a_ready_drops: assert property (take |=> !cmd_ready)
		else $error("slot stayed free after a take");
	a_ready_returns: assert property ($fell(cmd_ready) && !busy |-> ##[1:3] cmd_ready)
		else $error("slot not freed while the move runs");
	a_busy_starts: assert property (take && !busy |-> ##[1:3] busy)
		else $error("taken command did not start");
	a_steps_busy: assert property ((step_x || step_y) |-> busy)
		else $error("step issued while idle");
	a_centre_quiet: assert property (take && cmd_code == arc_centre_cmd && !busy
		|=> !(step_x || step_y) [*8])
		else $error("centre command made steps");
	a_linear_range: assert property (cmd_valid && cmd_code == linear_move_cmd
		|-> cmd_dx <= `LIN_MAX && cmd_dx >= -`LIN_MAX)
		else $error("linear operand out of range sent");
	a_linear_prof: assert property (cmd_valid && cmd_code == linear_move_cmd
		|-> cmd_profile inside {constant_speed, trapezoid})
		else $error("smooth profile sent with a linear move");
	a_chain_const: assert property (cmd_valid && cmd_code == linear_move_cmd && cmd_chain
		|-> cmd_profile == constant_speed)
		else $error("chained linear move not at constant speed");
	a_arc_const: assert property (cmd_valid && cmd_code inside {clockwise_arc_cmd,
		anticlockwise_arc_cmd} |-> cmd_profile == constant_speed)
		else $error("arc sent with a ramped profile");
	a_cmd_held: assert property (cmd_valid && !cmd_ready
		|=> cmd_valid && $stable(cmd_code) && $stable(cmd_dx))
		else $error("pending command changed before it was taken");
	cover property (take && cmd_code == linear_move_cmd);
	cover property (take && cmd_code == arc_centre_cmd);
	cover property (take && cmd_code == clockwise_arc_cmd);
	cover property (take && cmd_code == anticlockwise_arc_cmd);
endmodule

// File: sim/two_axis_interpolator_test.sv
// Self-checking bench for the sequencer and interpolator joined over the link.
`timescale 1ns/1ps
`include "intp_map.svh"
module two_axis_interpolator_test;
	import intp_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] rd;
	logic        err;
	logic        arm = 1'b0;
	logic        first_dy;
	int          n_errors = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          last_x = 0;
	int          gap_x = 0;
	int          net_x = 0;
	int          net_y = 0;
	int          tot_x = 0;
	int          tot_y = 0;
	int          exp_x = 0;
	int          exp_y = 0;
	int          tot0 = 0;
	int          toty0 = 0;
	intp_if lnk ();
	always #5 pclk = ~pclk;
	intp_sequencer i_intp_sequencer (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lnk(lnk.sequencer));
	intp_device i_intp_device (.pclk(pclk), .presetn(presetn), .ce(1'b1), .lnk(lnk.device));
	intp_monitor i_intp_monitor (.pclk(pclk), .presetn(presetn), .cmd_valid(lnk.cmd_valid),
		.cmd_ready(lnk.cmd_ready), .cmd_chain(lnk.cmd_chain), .cmd_code(lnk.cmd_code),
		.cmd_profile(lnk.cmd_profile), .cmd_dx(lnk.cmd_dx), .busy(lnk.busy),
		.step_x(lnk.step_x), .step_y(lnk.step_y));
	// ----------------------------------------
	// Step pulse bookkeeping.
	// ----------------------------------------
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (lnk.step_x === 1'b1) begin
			net_x <= net_x + (lnk.dir_x ? 1 : -1);
			tot_x <= tot_x + 1;
			gap_x <= cyc - last_x;
			last_x <= cyc;
		end
		if (lnk.step_y === 1'b1) begin
			net_y <= net_y + (lnk.dir_y ? 1 : -1);
			tot_y <= tot_y + 1;
			if (arm) begin
				first_dy <= lnk.dir_y;
				arm <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// Tasks.
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cmd(input cmd_t code, input logic [1:0] spd, input prof_t prof,
		input logic ch, input logic [31:0] dx, input logic [31:0] dy);
		apb(1'b1, `A_DX, dx);
		apb(1'b1, `A_DY, dy);
		apb(1'b1, `A_CMD, {25'h0000000, ch, prof, spd, code});
	endtask
	task automatic finish_move(input string what);
		for (int i = 0; i < 30 && lnk.busy !== 1'b1; i++) @(posedge pclk);
		for (int i = 0; i < 500; i++) begin
			apb(1'b0, `A_STATUS, 32'h00000000);
			if (rd[1:0] === 2'b00) break;
		end
		check({what, " status"}, 32'h00000000, rd);
		apb(1'b0, `A_POSX, 32'h00000000);
		check({what, " posx"}, exp_x, rd);
		apb(1'b0, `A_POSY, 32'h00000000);
		check({what, " posy"}, exp_y, rd);
		check({what, " pulses x"}, exp_x, net_x);
		check({what, " pulses y"}, exp_y, net_y);
		$display("test %s done", what);
	endtask
	task automatic refused(input string what);
		apb(1'b0, `A_STATUS, 32'h00000000);
		check(what, 32'h00000004, rd);
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----------------------------------------
	// Tests.
	// ----------------------------------------
	initial begin
		#400000;
		n_errors++;
		$display("ERROR watchdog expected done seen hang");
		give_verdict();
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `A_SCALE, 32'h00000000);
		check("scale reset", 32'h00010001, rd);
		apb(1'b0, 8'h10, 32'h00000000);
		check("period reset", 32'h000003E8, rd);
		apb(1'b0, 8'h3C, 32'h00000000);
		check("unmapped", 32'h00000001, {31'h00000000, err});
		for (int p = 0; p < 4; p++) apb(1'b1, 8'h10 + 8'(4 * p), 32'(4 + 2 * p));
		$display("test reset done");
		for (int s = 0; s < 4; s++) begin
			cmd(linear_move_cmd, s[1:0], constant_speed, 1'b0, 32'h00000003, 32'h00000000);
			exp_x += 3;
			finish_move("speed");
			check("step gap", 32'(4 + 2 * s), gap_x);
		end
		cmd(linear_move_cmd, 2'b00, constant_speed, 1'b0, 32'hFFFFFFFB, 32'h00000003);
		exp_x -= 5;
		exp_y += 3;
		finish_move("diagonal");
		cmd(linear_move_cmd, 2'b01, trapezoid, 1'b0, 32'h00000004, 32'hFFFFFFFC);
		exp_x += 4;
		exp_y -= 4;
		finish_move("trapezoid");
		cmd(linear_move_cmd, 2'b00, constant_speed, 1'b1, 32'h00000002, 32'h00000001);
		cmd(linear_move_cmd, 2'b00, constant_speed, 1'b1, 32'hFFFFFFFE, 32'h00000001);
		exp_y += 2;
		finish_move("chain");
		apb(1'b1, `A_SCALE, 32'h00020003);
		cmd(linear_move_cmd, 2'b00, constant_speed, 1'b0, 32'h00000004, 32'hFFFFFFFE);
		exp_x += 6;
		exp_y -= 3;
		finish_move("scale");
		apb(1'b1, `A_SCALE, 32'h00010001);
		cmd(linear_move_cmd, 2'b00, constant_speed, 1'b0, 32'h08000001, 32'h00000000);
		refused("linear range");
		cmd(linear_move_cmd, 2'b00, smooth_profile_one, 1'b0, 32'h00000001, 32'h00000001);
		refused("smooth one");
		cmd(linear_move_cmd, 2'b00, smooth_profile_two, 1'b0, 32'h00000001, 32'h00000001);
		refused("smooth two");
		cmd(linear_move_cmd, 2'b00, trapezoid, 1'b1, 32'h00000001, 32'h00000001);
		refused("chained ramp");
		cmd(clockwise_arc_cmd, 2'b00, trapezoid, 1'b0, 32'h00000000, 32'h00000000);
		refused("cw ramp");
		cmd(anticlockwise_arc_cmd, 2'b00, smooth_profile_two, 1'b0, 32'h00000000, 32'h00000000);
		refused("ccw smooth");
		$display("test refusals done");
		cmd(arc_centre_cmd, 2'b00, constant_speed, 1'b0, 32'h00000003, 32'h00000000);
		finish_move("centre");
		tot0 = tot_x;
		toty0 = tot_y;
		arm <= 1'b1;
		cmd(clockwise_arc_cmd, 2'b00, constant_speed, 1'b0, 32'h00000000, 32'h00000000);
		finish_move("full circle");
		check("circle x pulses", 32'd12, tot_x - tot0);
		check("circle y pulses", 32'd12, tot_y - toty0);
		check("cw first y dir", 32'h00000001, {31'h00000000, first_dy});
		arm <= 1'b1;
		cmd(anticlockwise_arc_cmd, 2'b00, constant_speed, 1'b0, 32'h00000006, 32'h00000000);
		exp_x += 6;
		finish_move("half circle");
		check("ccw first y dir", 32'h00000000, {31'h00000000, first_dy});
		give_verdict();
	end
endmodule
